// ---- psd_defines.svh ----
/*
  Constants of the paging decoder packet port: packet layout, packet
  identifiers, counter widths and reset values.
  Assumes it is included by its bare name and holds definitions only.
*/
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH

// packet layout, most significant bit shifted first
`define PSD_PKT_BITS      32
`define PSD_ID_BITS       8
`define PSD_INFO_BITS     24
`define PSD_ID_MSB        31
`define PSD_ID_LSB        24
`define PSD_INFO_MSB      23

// bit counter
`define PSD_CNT_W         6
`define PSD_CNT_ZERO      6'h00
`define PSD_CNT_ONE       6'h01
`define PSD_CNT_LAST      6'h1F

// identifiers
`define PSD_ID_CHECKSUM   8'h00
`define PSD_ID_STATUS     8'h7F
`define PSD_ID_PART       8'hFF
// identifiers 1C..1F share their upper six bits
`define PSD_SPECIAL_HI    6'h07
`define PSD_SPECIAL_TOP   7
`define PSD_SPECIAL_BOT   2

// reset values
`define PSD_CS_RST        24'h000000
`define PSD_WORD_RST      32'h00000000
`define PSD_SYNC_RST      3'h0
`define PSD_PIN_IDLE      3'h1

// pin positions inside the synchroniser vector
`define PSD_PIN_NUM       3
`define PSD_PIN_MOSI      0
`define PSD_PIN_SCK       1
`define PSD_PIN_SS        2

`endif

// ---- psd_pkg.sv ----
/*
  Types of the paging decoder packet port.
  Assumes nothing of its surroundings.
*/
package psd_pkg;

  typedef enum logic [1:0] {
    PSD_IDLE  = 2'b00,
    PSD_SHIFT = 2'b01,
    PSD_DONE  = 2'b10
  } psd_state_type;

endpackage : psd_pkg

// ---- psd_pkt_buffer.sv ----
/*
  Small packet buffer with valid/ready on both sides; entries live in
  flip-flops, so read data comes from a register.
  Assumes both sides run on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module psd_pkt_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;

  wire push = i_in_valid & o_in_ready;
  wire pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (count_r != CW'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= bump(wr_ptr_r);
      if (pop)  rd_ptr_r <= bump(rd_ptr_r);
      if (push & ~pop) count_r <= count_r + CW'(1);
      else if (pop & ~push) count_r <= count_r - CW'(1);
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) mem_r[g] <= '0;
        else if (push && wr_ptr_r == PW'(g)) mem_r[g] <= i_in_data;
      end
    end
  endgenerate

endmodule : psd_pkt_buffer

`default_nettype wire

// ---- psd_spi_slave.sv ----
/*
  Device end of the paging decoder packet port: a serial slave that
  exchanges whole 32-bit packets with a host, requests reads with an
  active-low ready line and withholds queued data until a matching
  checksum packet arrives.
  Assumes select, serial clock and host data come from another clock
  domain and are sampled here; the serial clock runs well below i_clk/6.
  Bits are taken on the rising serial clock edge and changed on the
  falling one, with the serial clock idling low.
*/
// Operation
// - packets are 8-bit id plus 24 info
// - each exchange carries valid packets both ways
// - host data on mosi, device data on miso
// - ready goes low once selected; code keeps it high while the receive buffer is full
// - device returns status when nothing queued and output enabled, part id while output withheld
// - host packet starts only on select fall
// - queued packet pulls ready low; code does so only while output enabled and the receive buffer has room
// - back-to-back device packets without deselect
// - msb first, identifier in top byte
// - xor info bits into checksum register
// - output withheld until checksum matches
// - id 00 checksum in, 7F status out
`timescale 1ns/1ps
`default_nettype none

`include "psd_defines.svh"

module psd_spi_slave
  import psd_pkg::*;
#(
  // info field of the part id packet; value is arbitrary
  parameter logic [`PSD_INFO_BITS-1:0] PART_INFO = 24'h000001,
  parameter int                        BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  // serial link pins
  input  wire logic                      i_ss_n,
  input  wire logic                      i_sck,
  input  wire logic                      i_mosi,
  output logic                           o_miso,
  output logic                           o_ready_n,
  // packets queued for the host
  input  wire logic                      i_tx_valid,
  input  wire logic [`PSD_PKT_BITS-1:0]  i_tx_data,
  output logic                           o_tx_ready,
  // info field of the status packet
  input  wire logic [`PSD_INFO_BITS-1:0] i_status_info,
  // packets received from the host
  output logic                           o_rx_valid,
  output logic      [`PSD_PKT_BITS-1:0]  o_rx_data,
  input  wire logic                      i_rx_ready,
  // port state
  output logic                           o_out_enabled,
  output logic      [`PSD_INFO_BITS-1:0] o_checksum
);

  // pin synchronisers
  logic [`PSD_PIN_NUM-1:0] pin_in;
  logic [`PSD_PIN_NUM-1:0] sync1_r;
  logic [`PSD_PIN_NUM-1:0] sync2_r;
  logic                    ss_prev_r;
  logic                    sck_prev_r;

  // packet engine
  psd_state_type           state_r;
  psd_state_type           state_nxt;
  logic [`PSD_CNT_W-1:0]   cnt_r;
  logic [`PSD_PKT_BITS-1:0] shin_r;
  logic [`PSD_PKT_BITS-1:0] shout_r;
  logic                    used_tx_r;
  logic                    ready_n_r;

  // checksum state
  logic [`PSD_INFO_BITS-1:0] cs_r;
  logic                      enabled_r;

  // buffer handshake
  logic                    buf_in_ready;

  assign pin_in = {i_ss_n, i_sck, i_mosi};

  // every pin passes two flops; only the second stage is read.
  // reset values equal the idle pin levels, so leaving reset shows
  // neither a select fall nor a serial clock edge
  genvar g;
  generate
    for (g = 0; g < `PSD_PIN_NUM; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sync1_r[g] <= (g == `PSD_PIN_SS);
          sync2_r[g] <= (g == `PSD_PIN_SS);
        end else begin
          sync1_r[g] <= pin_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  wire ss_s   = sync2_r[`PSD_PIN_SS];
  wire sck_s  = sync2_r[`PSD_PIN_SCK];
  wire mosi_s = sync2_r[`PSD_PIN_MOSI];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ss_prev_r  <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      ss_prev_r  <= ss_s;
      sck_prev_r <= sck_s;
    end
  end

  // edges show up three clocks after the pin moves; a serial clock
  // half period under three clocks could hide one inside that delay
  wire ss_fall  = ss_prev_r & ~ss_s;
  wire sck_rise = ~sck_prev_r & sck_s;
  wire sck_fall = sck_prev_r & ~sck_s;

  // identifier 1C..1F packets are neither summed nor passed on
  function automatic logic is_special(input logic [`PSD_ID_BITS-1:0] id);
    is_special = (id[`PSD_SPECIAL_TOP:`PSD_SPECIAL_BOT] == `PSD_SPECIAL_HI);
  endfunction : is_special

  // id 00 from the host carries the checksum value
  function automatic logic is_checksum(input logic [`PSD_ID_BITS-1:0] id);
    is_checksum = (id == `PSD_ID_CHECKSUM);
  endfunction : is_checksum

  // received packet fields, split at the top byte
  wire [`PSD_ID_BITS-1:0]   rx_id   = shin_r[`PSD_ID_MSB:`PSD_ID_LSB];
  wire [`PSD_INFO_BITS-1:0] rx_info = shin_r[`PSD_INFO_MSB:0];
  wire rx_cs      = is_checksum(rx_id);
  wire rx_special = is_special(rx_id);
  wire done       = (state_r == PSD_DONE);
  wire rx_forward = done & ~rx_cs & ~rx_special;

  // the queued word is taken only by a completed exchange
  wire tx_take = done & used_tx_r;
  assign o_tx_ready = tx_take;

  // a read request waits for room in the buffer, so the host's word
  // sent during the read is never dropped
  wire req = enabled_r & i_tx_valid & buf_in_ready & ~tx_take;
  // limitation: while output is withheld no read is ever requested;
  // the host learns of the state only from its own exchanges

  // host packets need a fresh select fall; device packets may run on
  // while select stays low
  wire idle       = (state_r == PSD_IDLE);
  wire start_host = idle & ss_fall & buf_in_ready;
  wire start_dev  = idle & ~ss_s & req;
  wire start      = start_host | start_dev;
  // a select fall that lands in the done cycle is not a new packet,
  // so a host keeps select high for at least three clocks between

  // outgoing word: queued data, else status, else part id
  wire use_tx = enabled_r & i_tx_valid;
  wire [`PSD_PKT_BITS-1:0] status_word = {`PSD_ID_STATUS, i_status_info};
  wire [`PSD_PKT_BITS-1:0] part_word   = {`PSD_ID_PART, PART_INFO};
  wire [`PSD_PKT_BITS-1:0] load_word   =
    use_tx ? i_tx_data : (enabled_r ? status_word : part_word);
  // status info is taken once per packet at start, so a change while
  // shifting shows in the next status packet, never half in this one

  // an abandoned packet leaves count and shift words stale; the next
  // start reloads the count and outgoing word, the 32 bits of the next
  // packet overwrite the incoming word, and nothing else acts on a packet before done
  wire shifting = (state_r == PSD_SHIFT);
  wire abort    = shifting & ss_s;
  wire last_in  = shifting & ~ss_s & sck_rise &
                  (cnt_r == `PSD_CNT_LAST);

  // done lasts one clock and is the only cycle in which a packet is
  // judged, so the enable is never set and cleared at once

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSD_IDLE:  if (start) state_nxt = PSD_SHIFT;
      PSD_SHIFT: begin
        if (abort) state_nxt = PSD_IDLE;
        else if (last_in) state_nxt = PSD_DONE;
      end
      PSD_DONE:  state_nxt = PSD_IDLE;
      default:   state_nxt = PSD_IDLE;
    endcase
  end

  // ready is low for the whole packet, and between packets only while
  // a read is wanted
  wire ready_n_nxt = ~((state_nxt == PSD_SHIFT) |
                       ((state_nxt == PSD_IDLE) & req));

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r   <= PSD_IDLE;
      ready_n_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      ready_n_r <= ready_n_nxt;
    end
  end

  // shift engine: take mosi on rising edges, move miso on falling
  // edges; the trailing fall of the previous packet sees a zero count
  // and leaves the freshly loaded msb alone
  wire shift_in  = (state_r == PSD_SHIFT) & ~ss_s & sck_rise;
  wire shift_out = (state_r == PSD_SHIFT) & ~ss_s & sck_fall &
                   (cnt_r != `PSD_CNT_ZERO);

  // used_tx_r remembers whether the queued word went out, so the take
  // pulse in done never drops a word that was not shifted
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r     <= `PSD_CNT_ZERO;
      used_tx_r <= 1'b0;
    end else if (start) begin
      cnt_r     <= `PSD_CNT_ZERO;
      used_tx_r <= use_tx;
    end else if (shift_in) begin
      cnt_r     <= cnt_r + `PSD_CNT_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) shin_r <= `PSD_WORD_RST;
    else if (shift_in) shin_r <= {shin_r[`PSD_PKT_BITS-2:0], mosi_s};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) shout_r <= `PSD_WORD_RST;
    else if (start) shout_r <= load_word;
    else if (shift_out) shout_r <= {shout_r[`PSD_PKT_BITS-2:0], 1'b0};
  end

  // checksum: a matching checksum packet clears the register and
  // enables output; any other counted packet disables it until the
  // next match. clearing on match lets a zero checksum keep output
  // enabled while the host idles
  wire [`PSD_INFO_BITS-1:0] cs_mix = cs_r ^ rx_info;
  wire cs_match = done & rx_cs & (cs_mix == `PSD_CS_RST);
  wire cs_miss  = done & rx_cs & (cs_mix != `PSD_CS_RST);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_r      <= `PSD_CS_RST;
      enabled_r <= 1'b0;
    end else if (cs_match) begin
      cs_r      <= `PSD_CS_RST;
      enabled_r <= 1'b1;
    end else if (cs_miss) begin
      enabled_r <= 1'b0;
    end else if (rx_forward) begin
      cs_r      <= cs_mix;
      enabled_r <= 1'b0;
    end
  end

  // trade-off: refusing a select fall while the buffer is full costs
  // the host a retry, but no host word is ever dropped.
  // received packets for the core; a stall fills the buffer, which
  // then holds off the next exchange through buf_in_ready
  psd_pkt_buffer #(
    .WIDTH (`PSD_PKT_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (rx_forward),
    .i_in_data   (shin_r),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  // miso keeps the last shifted bit between packets; the host reads
  // it only while ready is low
  assign o_miso        = shout_r[`PSD_ID_MSB];
  assign o_ready_n     = ready_n_r;
  assign o_out_enabled = enabled_r;
  assign o_checksum    = cs_r;

endmodule : psd_spi_slave

`default_nettype wire

// ---- psd_spi_chk.sv ----
/*
  Concurrent checks on the link pins and core-side ports of the packet port.
  Assumes it is bound to psd_spi_slave and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

`include "psd_defines.svh"

module psd_spi_chk (
  // clock and reset
  input wire logic                      i_clk,
  input wire logic                      i_rstn,
  // link pins
  input wire logic                      i_ss_n,
  input wire logic                      i_sck,
  input wire logic                      o_miso,
  input wire logic                      o_ready_n,
  // core side
  input wire logic                      i_tx_valid,
  input wire logic                      o_tx_ready,
  input wire logic                      o_rx_valid,
  input wire logic [`PSD_PKT_BITS-1:0]  o_rx_data,
  input wire logic                      i_rx_ready,
  input wire logic                      o_out_enabled,
  input wire logic [`PSD_INFO_BITS-1:0] o_checksum
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  tx_pulse_a:
    assert property (o_tx_ready |-> i_tx_valid ##1 !o_tx_ready)
    else $error("tx take is not a single pulse");
  tx_enabled_a:
    assert property (o_tx_ready |-> o_out_enabled)
    else $error("queued packet sent while output withheld");
  cs_clear_a:
    assert property ($rose(o_out_enabled) |-> o_checksum == `PSD_CS_RST)
    else $error("output enabled without a cleared checksum");
  cs_change_a:
    assert property ($changed(o_checksum) |-> $past(o_ready_n, 2) == 1'b0)
    else $error("checksum moved outside an exchange");
  rx_hold_a:
    assert property (o_rx_valid && !i_rx_ready |=>
                     o_rx_valid && $stable(o_rx_data))
    else $error("received packet lost while stalled");
  miso_hold_a:
    assert property (i_sck && $past(i_sck) |-> $stable(o_miso))
    else $error("device data moved while serial clock high");
  reset_idle_a:
    assert property ($rose(i_rstn) |-> o_ready_n && !o_out_enabled)
    else $error("port not idle after reset");
  ready_sel_a:
    assert property ($fell(o_ready_n) |->
                     !i_ss_n || (o_out_enabled && i_tx_valid))
    else $error("ready asserted with no select and no read");
endmodule : psd_spi_chk

bind psd_spi_slave psd_spi_chk u_chk (
  .i_clk, .i_rstn, .i_ss_n, .i_sck, .o_miso, .o_ready_n, .i_tx_valid,
  .o_tx_ready, .o_rx_valid, .o_rx_data, .i_rx_ready, .o_out_enabled,
  .o_checksum);

`default_nettype wire

// ---- psd_host_model.sv ----
/*
  Host model: serial master that selects, waits for ready, shifts packets.
  Assumes the bench calls xfer one transfer at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module psd_host_model (
  // clock
  input  wire logic i_clk,
  // link pins
  output logic      o_ss_n,
  output logic      o_sck,
  output logic      o_mosi,
  input  wire logic i_miso,
  input  wire logic i_ready_n
);
  initial begin
    o_ss_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end

  // host owns clock and select
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      input bit fresh, input bit keep,
                      output logic [31:0] rx, output bit ok);
    int n;
    rx = 32'h00000000;
    if (fresh) begin
      // let an edge pass so a deselect from the last call is not redriven
      @(posedge i_clk);
      o_ss_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ss_n <= 1'b0;
    end
    repeat (3) @(posedge i_clk);
    for (n = 0; n < 40 && i_ready_n !== 1'b0; n++) @(posedge i_clk);
    ok = (i_ready_n === 1'b0);
    for (n = 31; ok && n > 31 - nbits; n--) begin
      o_mosi <= tx[n];
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      // sample mid-high so the device's update after the fall has landed
      repeat (2) @(posedge i_clk);
      rx[n] = i_miso;
      repeat (2) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    // released data line must not keep showing the last bit
    o_mosi <= ~o_mosi;
    if (!keep) o_ss_n <= 1'b1;
  endtask : xfer
endmodule : psd_host_model

`default_nettype wire

// ---- test_paging_decoder_packet_spi.sv ----
/*
  Self-checking bench for the packet port: host model on the link side,
  queues on the core side.
  Assumes psd_spi_chk is bound to the device.
*/
`timescale 1ns/1ps
`default_nettype none

module test_paging_decoder_packet_spi;
  localparam logic [23:0] PINFO = 24'h000001; // arbitrary value
  localparam logic [23:0] STAT  = 24'hA5A5A5;
  logic        clk, rstn, ss_n, sck, mosi, miso, ready_n;
  logic        tx_ready, rx_valid, rx_ready, out_en;
  logic        tx_valid = 1'b0;
  logic [31:0] tx_data  = 32'h00000000;
  logic [31:0] rx_data, got, d;
  logic [23:0] status_info, cs;
  logic [31:0] txq[$];
  int          miscompares = 0, compares = 0;
  bit          ok;

  psd_spi_slave #(.PART_INFO(PINFO), .BUF_DEPTH(2)) dut (
    .i_clk(clk), .i_rstn(rstn), .i_ss_n(ss_n), .i_sck(sck), .i_mosi(mosi),
    .o_miso(miso), .o_ready_n(ready_n), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_tx_ready(tx_ready), .i_status_info(status_info),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .o_out_enabled(out_en), .o_checksum(cs));
  psd_host_model host (.i_clk(clk), .o_ss_n(ss_n), .o_sck(sck),
    .o_mosi(mosi), .i_miso(miso), .i_ready_n(ready_n));

  always #12.5 clk = ~clk;

  // keep valid up across takes so back-to-back reads see a pending packet
  always @(posedge clk) begin
    if ((tx_ready || !tx_valid) && txq.size() > 0) begin
      tx_valid <= 1'b1;
      tx_data  <= txq.pop_front();
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic pop_rx(output logic [31:0] v);
    int n;
    // read only after an edge, so a pop made by the last call has landed
    @(posedge clk);
    for (n = 0; n < 20 && rx_valid !== 1'b1; n++) @(posedge clk);
    v = (rx_valid === 1'b1) ? rx_data : 32'hXXXXXXXX;
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask : pop_rx

  task automatic t_write();
    check({30'h0, ready_n, out_en}, 32'h2);
    host.xfer(32'h01123456, 32, 1'b1, 1'b0, got, ok);
    check(got, {8'hFF, PINFO});
    pop_rx(d);
    check(d, 32'h01123456);
    check({8'h0, cs}, 32'h00123456);
    $display("test write done");
  endtask : t_write

  task automatic t_ignored();
    logic [7:0] id;
    for (id = 8'h1C; id <= 8'h1F; id++) begin
      host.xfer({id, 24'hFFFFFF}, 32, 1'b1, 1'b0, got, ok);
      check({8'h0, cs}, 32'h00123456);
    end
    host.xfer(32'h0200000F, 16, 1'b1, 1'b0, got, ok);
    check({8'h0, cs}, 32'h00123456);
    check({31'h0, rx_valid}, 32'h0);
    $display("test ignored done");
  endtask : t_ignored

  task automatic t_checksum();
    host.xfer(32'h00000001, 32, 1'b1, 1'b0, got, ok);
    check({7'h0, out_en, cs}, 32'h00123456);
    host.xfer(32'h00123456, 32, 1'b1, 1'b0, got, ok);
    check({7'h0, out_en, cs}, 32'h01000000);
    host.xfer(32'h00000000, 32, 1'b1, 1'b0, got, ok);
    check(got, {8'h7F, STAT});
    $display("test checksum done");
  endtask : t_checksum

  task automatic t_read();
    txq.push_back(32'h01111111);
    txq.push_back(32'h02222222);
    host.xfer(32'h00000000, 32, 1'b1, 1'b1, got, ok);
    check(got, 32'h01111111);
    host.xfer(32'h00000000, 32, 1'b0, 1'b1, got, ok);
    check(got, 32'h02222222);
    check({31'h0, ready_n}, 32'h1);
    host.xfer(32'h00000000, 32, 1'b1, 1'b0, got, ok);
    check(got, {8'h7F, STAT});
    check({30'h0, out_en, rx_valid}, 32'h2);
    $display("test read done");
  endtask : t_read

  task automatic t_fill();
    host.xfer(32'h03000001, 32, 1'b1, 1'b0, got, ok);
    host.xfer(32'h04000002, 32, 1'b1, 1'b0, got, ok);
    host.xfer(32'h05000004, 32, 1'b1, 1'b0, got, ok);
    check({31'h0, ok}, 32'h0);
    pop_rx(d);
    check(d, 32'h03000001);
    pop_rx(d);
    check(d, 32'h04000002);
    check({7'h0, out_en, cs}, 32'h00000003);
    $display("test fill done");
  endtask : t_fill

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #500000;
    miscompares++;
    close_out();
  end

  initial begin
    clk         = 1'b0;
    rstn        = 1'b0;
    rx_ready    = 1'b0;
    status_info = STAT;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_write();
    t_ignored();
    t_checksum();
    t_read();
    t_fill();
    close_out();
  end
endmodule : test_paging_decoder_packet_spi

`default_nettype wire
